/* fault_retry_sequencer.sv */
// Functional notes
// R1: Code 11 latches output off until cleared.
// R2: Status-bit clear or clear-faults command clears.
// R3: Reset input clears latch and releases hold.
// R4: Commanding output off then on clears.
// R5: Retry field 000 means no restart.
// R6: Codes 001-110 give one to six attempts.
// R7: Attempt starts spaced by programmed delay.
// R8: Code 111 retries until off or reset.
// R9: Delay equals two to the field units.
// R10: Delay serves grace or retry spacing.
// R11: Unit length comes from separate register.
// R12: Code 00 ignores the fault entirely.
// R13: Code 01 runs through delay, then retries.
// R14: Code 10 disables at once, then retries.
// R15: Fault during an attempt counts as failure.
`include "fault_retry_defines.svh"
`default_nettype none
module fault_retry_sequencer
  import fault_retry_pkg::*;
#(
  parameter int UNIT_W = 16
) (
  input  wire logic              sys_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              fault_reset_in,
  input  wire logic              cmd_valid_in,
  input  wire logic [7:0]        cmd_code_in,
  input  wire logic [7:0]        cmd_data_in,
  input  wire logic              status_clear_in,
  input  wire logic              on_cmd_in,
  input  wire logic              fault_in,
  input  wire logic [UNIT_W-1:0] time_unit_in,
  output logic [7:0]             cfg_rd_data_out,
  output logic                   output_enable_out,
  output logic                   fault_status_out,
  output logic                   retry_active_out,
  output logic [2:0]             attempt_count_out
);
  import fault_retry_pkg::*;

  initial begin
    if (UNIT_W < 1 || UNIT_W > 31) $error("fault_retry_sequencer: UNIT_W out of range");
  end

  seq_s       s_ff;
  seq_s       nxt_s;
  logic       tick;
  logic       tmr_start;
  logic       retry_act_ff;
  logic       nxt_retry_act;
  logic       expire;
  logic       on_rise;
  logic       clear_evt;
  logic       fault_set;
  logic [1:0] resp;
  logic [2:0] retries;
  logic [2:0] dly;

  // Unit length is supplied by the separate time-unit register outside.
  unit_tick_gen #(
    .W          (UNIT_W)
  ) u_tick (
    .clk_in     (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .restart_in (tmr_start),
    .period_in  (time_unit_in),
    .tick_out   (tick)
  ); // R11

  always_comb begin
    nxt_s         = s_ff;
    tmr_start     = 1'b0;
    fault_set     = 1'b0;
    resp          = s_ff.cfg[`FR_RESP_MSB:`FR_RESP_LSB];
    retries       = s_ff.cfg[`FR_RETRY_MSB:`FR_RETRY_LSB];
    dly           = s_ff.cfg[`FR_DELAY_MSB:`FR_DELAY_LSB];
    expire        = s_ff.tmr_on && tick && (s_ff.tmr_units == `FR_UNITS_ONE);
    on_rise       = on_cmd_in && !s_ff.on_prev;
    nxt_s.on_prev = on_cmd_in;
    clear_evt     = status_clear_in || on_rise || fault_reset_in ||
                    (cmd_valid_in && cmd_code_in == `FR_CMD_CLEAR_FAULTS); // R2 R4 R3

    if (s_ff.tmr_on && tick) begin
      nxt_s.tmr_units = s_ff.tmr_units - `FR_UNITS_ONE;
    end
    if (expire) begin
      nxt_s.tmr_on = 1'b0;
    end

    if (cmd_valid_in && cmd_code_in == `FR_CMD_RESPONSE) begin
      nxt_s.cfg = cmd_data_in;
    end

    unique case (s_ff.state)
      ST_RUN: begin
        if (fault_in && on_cmd_in) begin
          unique case (resp)
            RESP_IGNORE: begin
              nxt_s.state = ST_RUN; // R12
            end
            RESP_GRACE: begin
              fault_set   = 1'b1;
              nxt_s.state = ST_GRACE; // R13
              tmr_start   = 1'b1; // R10
            end
            RESP_RETRY: begin
              fault_set = 1'b1;
              if (retries == `FR_RETRY_NONE) begin
                nxt_s.state = ST_LATCH; // R5
              end else begin
                nxt_s.state = ST_HOLD; // R14
                tmr_start   = 1'b1;
              end
            end
            RESP_LATCH: begin
              fault_set   = 1'b1;
              nxt_s.state = ST_LATCH; // R1
            end
          endcase
        end
      end
      ST_GRACE: begin
        if (expire) begin
          if (!fault_in) begin
            nxt_s.state = ST_RUN;
          end else if (retries == `FR_RETRY_NONE) begin
            nxt_s.state = ST_LATCH; // R5
          end else begin
            nxt_s.state = ST_HOLD; // R13
            tmr_start   = 1'b1;
          end
        end
      end
      ST_HOLD: begin
        // The timer keeps running from the previous attempt start, so the
        // next attempt begins exactly one delay after the last one began.
        if (expire) begin
          nxt_s.state    = ST_TRY;
          nxt_s.attempts = s_ff.attempts + 3'h1;
          tmr_start      = 1'b1; // R7
        end
      end
      ST_TRY: begin
        if (fault_in) begin
          fault_set = 1'b1; // R15
          if (retries == `FR_RETRY_FOREVER || s_ff.attempts < retries) begin
            nxt_s.state = ST_HOLD; // R8 R6
          end else begin
            nxt_s.state = ST_LATCH; // R6
          end
        end else if (expire) begin
          nxt_s.state    = ST_RUN;
          nxt_s.attempts = 3'h0;
        end
      end
      ST_LATCH: begin
        if (clear_evt) begin
          nxt_s.state    = ST_RUN; // R1 R2 R4
          nxt_s.attempts = 3'h0;
        end
      end
    endcase

    // Commanding the output off abandons any grace period or retry sequence.
    if (!on_cmd_in && s_ff.state != ST_LATCH) begin
      nxt_s.state    = ST_RUN; // R8
      nxt_s.attempts = 3'h0;
      nxt_s.tmr_on   = 1'b0;
      tmr_start      = 1'b0;
    end

    if (fault_reset_in) begin
      nxt_s.state    = ST_RUN; // R3
      nxt_s.attempts = 3'h0;
      nxt_s.tmr_on   = 1'b0;
      tmr_start      = 1'b0;
    end

    if (tmr_start) begin
      nxt_s.tmr_on    = 1'b1;
      nxt_s.tmr_units = `FR_UNITS_ONE << dly; // R9
    end

    // A new fault in the same cycle as a clear keeps the status bit set.
    if (fault_set) begin
      nxt_s.status = 1'b1;
    end else if (clear_evt) begin
      nxt_s.status = 1'b0; // R2
    end

    nxt_s.out_en  = on_cmd_in &&
                    (nxt_s.state == ST_RUN || nxt_s.state == ST_GRACE ||
                     nxt_s.state == ST_TRY);
    nxt_retry_act = (nxt_s.state == ST_HOLD || nxt_s.state == ST_TRY);
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_ff         <= '{state: ST_RUN, cfg: `FR_CFG_RESET, attempts: 3'h0,
                        tmr_units: 8'h00, tmr_on: 1'b0, status: 1'b0,
                        on_prev: 1'b0, out_en: 1'b0};
      retry_act_ff <= 1'b0;
    end else begin
      s_ff         <= nxt_s;
      retry_act_ff <= nxt_retry_act;
    end
  end

  assign cfg_rd_data_out   = s_ff.cfg;
  assign output_enable_out = s_ff.out_en;
  assign fault_status_out  = s_ff.status;
  assign retry_active_out  = retry_act_ff;
  assign attempt_count_out = s_ff.attempts;

endmodule // fault_retry_sequencer
`default_nettype wire

/* fault_retry_defines.svh */
`ifndef FAULT_RETRY_DEFINES_SVH
`define FAULT_RETRY_DEFINES_SVH

// Management command codes; this block decodes only the response and clear-faults codes.
`define FR_CMD_RESPONSE      8'h50
`define FR_CMD_CLEAR_FAULTS  8'h03
`define FR_CMD_TIME_UNIT     8'hD2

// Field layout of the response configuration byte.
`define FR_RESP_MSB          7
`define FR_RESP_LSB          6
`define FR_RETRY_MSB         5
`define FR_RETRY_LSB         3
`define FR_DELAY_MSB         2
`define FR_DELAY_LSB         0

// Reset values and timing counts.
`define FR_CFG_RESET         8'h80
`define FR_RETRY_NONE        3'h0
`define FR_RETRY_FOREVER     3'h7
`define FR_UNITS_ONE         8'h01

`endif

/* fault_retry_pkg.sv */
`default_nettype none
package fault_retry_pkg;

  typedef enum logic [4:0] {
    ST_RUN   = 5'b00001,
    ST_GRACE = 5'b00010,
    ST_HOLD  = 5'b00100,
    ST_TRY   = 5'b01000,
    ST_LATCH = 5'b10000
  } seq_state_e;

  typedef enum logic [1:0] {
    RESP_IGNORE  = 2'h0,
    RESP_GRACE   = 2'h1,
    RESP_RETRY   = 2'h2,
    RESP_LATCH   = 2'h3
  } response_e;

  typedef struct packed {
    seq_state_e state;
    logic [7:0] cfg;
    logic [2:0] attempts;
    logic [7:0] tmr_units;
    logic       tmr_on;
    logic       status;
    logic       on_prev;
    logic       out_en;
  } seq_s;

endpackage
`default_nettype wire

/* unit_tick_gen.sv */
`default_nettype none
module unit_tick_gen #(
  parameter int W = 16
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         restart_in,
  input  wire logic [W-1:0] period_in,
  output logic              tick_out
);

  initial begin
    if (W < 1 || W > 31) $error("unit_tick_gen: W out of range");
  end

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // A period of zero is served as one cycle so the timer can never stall.
  always_comb begin
    tick_out = (cnt_ff + W'(1) >= period_in);
    if (restart_in || tick_out) begin
      nxt_cnt = '0;
    end else begin
      nxt_cnt = cnt_ff + W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule // unit_tick_gen
`default_nettype wire

/* fault_retry_sequencer_assertions.sv */
`default_nettype none
module fault_retry_sequencer_checker #(
  parameter int UNIT_W = 16
) (
  input wire logic              sys_clk_in,
  input wire logic              rst_n_in,
  input wire logic              fault_reset_in,
  input wire logic              cmd_valid_in,
  input wire logic [7:0]        cmd_code_in,
  input wire logic [7:0]        cmd_data_in,
  input wire logic              status_clear_in,
  input wire logic              on_cmd_in,
  input wire logic              fault_in,
  input wire logic [UNIT_W-1:0] time_unit_in,
  input wire logic [7:0]        cfg_rd_data_out,
  input wire logic              output_enable_out,
  input wire logic              fault_status_out,
  input wire logic              retry_active_out,
  input wire logic [2:0]        attempt_count_out
);
  logic [15:0] gap_ff;
  logic [31:0] span;
  assign span = (32'h1 << cfg_rd_data_out[2:0]) *
                ((time_unit_in == '0) ? 32'h1 : 32'(time_unit_in));
  // Cycles between changes of the attempt count give the attempt spacing.
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
    if (!rst_n_in) gap_ff <= 16'h0001;
    else gap_ff <= $changed(attempt_count_out) ? 16'h0001 : gap_ff + 16'h0001;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_IGNORE_FAULT: assert property (
    cfg_rd_data_out[7:6] == 2'h0 && on_cmd_in && output_enable_out && !cmd_valid_in
    |=> output_enable_out) else $error("output dropped while ignoring");
  AST_DISABLE_NOW: assert property (
    cfg_rd_data_out[7] && fault_in && on_cmd_in && output_enable_out && !retry_active_out
    && !cmd_valid_in && !fault_reset_in |=> !output_enable_out) else $error("no shutdown");
  AST_LATCH_STAYS: assert property (
    !output_enable_out && fault_status_out && !retry_active_out && on_cmd_in
    && $past(on_cmd_in) && !cmd_valid_in && !status_clear_in && !fault_reset_in
    |=> !output_enable_out) else $error("latched output came back");
  AST_CLEAR_STATUS: assert property (
    (status_clear_in || (cmd_valid_in && cmd_code_in == 8'h03)) && !fault_in
    |=> !fault_status_out) else $error("status not cleared");
  AST_RESET_RUN: assert property (
    fault_reset_in && !fault_in |=> !retry_active_out && attempt_count_out == 3'h0)
    else $error("reset input left sequence running");
  AST_RETRY_LIMIT: assert property (
    cfg_rd_data_out[5:3] != 3'h7 |-> attempt_count_out <= cfg_rd_data_out[5:3])
    else $error("too many attempts");
  AST_OFF_STOPS: assert property (
    !on_cmd_in |=> !output_enable_out && !retry_active_out) else $error("off ignored");
  AST_ATTEMPT_GAP: assert property (
    $changed(attempt_count_out) && attempt_count_out > $past(attempt_count_out)
    && $past(attempt_count_out) != 3'h0 |-> 32'(gap_ff) == span)
    else $error("attempt spacing wrong");
endmodule // fault_retry_sequencer_checker
bind fault_retry_sequencer fault_retry_sequencer_checker #(.UNIT_W(UNIT_W)) chk_u (.*);
`default_nettype wire

/* fault_host_model.sv */
`default_nettype none
module fault_host_model (
  input wire logic       sys_clk_in,
  input wire logic       go_in,
  input wire logic [7:0] code_in,
  input wire logic [7:0] data_in,
  output logic           cmd_valid_out,
  output logic [7:0]     cmd_code_out,
  output logic [7:0]     cmd_data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       g;
  logic [7:0] c;
  logic [7:0] d;
  initial begin
    cmd_valid_out = 1'b0;
    cmd_code_out = 8'h00;
    cmd_data_out = 8'h00;
  end
  // Idle bytes toggle so stale command values are never mistaken for fresh ones.
  always @(posedge sys_clk_in) begin
    g = go_in;
    c = code_in;
    d = data_in;
    #2;
    cmd_valid_out = g;
    cmd_code_out = g ? c : ~cmd_code_out;
    cmd_data_out = g ? d : ~cmd_data_out;
  end
endmodule // fault_host_model
`default_nettype wire

/* tb_fault_retry_sequencer.sv */
`default_nettype none
module tb_fault_retry_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk_in, rst_n_in, fault_reset_in, cmd_valid_in, status_clear_in;
  logic        on_cmd_in, fault_in, host_go, output_enable_out, fault_status_out;
  logic        retry_active_out;
  logic [7:0]  cmd_code_in, cmd_data_in, host_code, host_data, cfg_rd_data_out, cfg;
  logic [15:0] time_unit_in;
  logic [2:0]  attempt_count_out;
  int          fail_count = 0;
  int          checks_done = 0;
  int          n;
  fault_retry_sequencer dut_u (.*);
  fault_host_model host_u (.sys_clk_in(sys_clk_in), .go_in(host_go), .code_in(host_code),
    .data_in(host_data), .cmd_valid_out(cmd_valid_in), .cmd_code_out(cmd_code_in),
    .cmd_data_out(cmd_data_in));
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_in);
    #2;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic host(input logic [7:0] code, input logic [7:0] data);
    host_go = 1'b1;
    host_code = code;
    host_data = data;
    tick(1);
    host_go = 1'b0;
    tick(2);
  endtask
  function automatic int span(input logic [7:0] c, input int u);
    return (1 << c[2:0]) * u;
  endfunction
  // Restart from a clean run state with a new response byte, then raise the fault.
  task automatic arm(input logic [7:0] c);
    fault_in = 1'b0;
    fault_reset_in = 1'b1;
    tick(1);
    fault_reset_in = 1'b0;
    host(8'h50, c);
    check("cfg", cfg_rd_data_out, c);
    check("on", output_enable_out, 8'h01);
    fault_in = 1'b1;
    tick(1);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(25 * 6000);
    fail_count++;
    close_out();
  end
  initial begin
    {rst_n_in, fault_reset_in, status_clear_in, on_cmd_in, fault_in, host_go} = 6'h00;
    {host_code, host_data} = 16'h0000;
    time_unit_in = 16'h0002;
    void'($urandom(69551));
    tick(12);
    check("cfg reset", cfg_rd_data_out, 8'h80);
    check("out reset", output_enable_out, 8'h00);
    check("status reset", fault_status_out, 8'h00);
    rst_n_in = 1'b1;
    on_cmd_in = 1'b1;
    tick(3);
    arm({2'h0, 6'($urandom)});
    tick(10);
    check("ignore", output_enable_out, 8'h01);
    $display("test ignore ended");
    for (n = 0; n < 4; n++) begin
      arm({2'h3, 6'($urandom)});
      check("latch", output_enable_out, 8'h00);
      tick(20);
      fault_in = 1'b0;
      check("held", output_enable_out, 8'h00);
      case (n)
        0: begin status_clear_in = 1'b1; tick(1); status_clear_in = 1'b0; end
        1: host(8'h03, 8'h00);
        2: begin fault_reset_in = 1'b1; tick(1); fault_reset_in = 1'b0; end
        default: begin on_cmd_in = 1'b0; tick(2); on_cmd_in = 1'b1; tick(1); end
      endcase
      tick(3);
      check("cleared", output_enable_out, 8'h01);
      if (n < 2) check("status", fault_status_out, 8'h00);
    end
    $display("test latch ended");
    for (n = 0; n < 7; n++) begin
      time_unit_in = 16'($urandom_range(1, 3));
      cfg = {2'h2, 3'(n), 3'($urandom_range(0, 2))};
      arm(cfg);
      check("off now", output_enable_out, 8'h00);
      tick(span(cfg, int'(time_unit_in)) * (n + 1) + 10);
      check("attempts", attempt_count_out, 8'(n));
      check("gave up", output_enable_out | retry_active_out, 8'h00);
    end
    $display("test retries ended");
    arm(8'hB9);
    tick(60);
    check("forever", retry_active_out, 8'h01);
    fault_in = 1'b0;
    tick(3 * span(8'hB9, int'(time_unit_in)) + 5);
    check("recovered", output_enable_out, 8'h01);
    arm(8'hB9);
    tick(40);
    on_cmd_in = 1'b0;
    tick(1);
    check("stopped", output_enable_out | retry_active_out, 8'h00);
    on_cmd_in = 1'b1;
    time_unit_in = 16'h0002;
    arm(8'h43);
    tick(6);
    check("grace on", output_enable_out, 8'h01);
    tick(20);
    check("grace off", output_enable_out, 8'h00);
    $display("test continuous and grace ended");
    close_out();
  end
endmodule // tb_fault_retry_sequencer
`default_nettype wire
